/* File: uvp_stage.sv */
// Purpose: shared constants of the undervoltage block and one threshold
//   stage (pickup latch with hysteresis, common delay timer, expiry).
// Assumes: comparisons, qualifiers and blocks arrive on the same clock.
// Notes: delay settings count in ticks of TICK_PERIOD_NS.
package uvp_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int VW = 16;
	localparam int TW = 16;
	localparam int RATIO_FRAC = 8;
	localparam logic [16:0] SQRT3_HALF = 17'h0DDB4;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ON = 2'h1;
	localparam logic [1:0] MODE_ALARM = 2'h2;
	localparam logic [1:0] MODE_A1_T2 = 2'h3;
	localparam int BIN_PE = 0;
	localparam int BIN_PP = 1;
	localparam int BIN_PS = 2;
	localparam int BIN_VT = 3;

	// stage may trip under this mode
	function automatic logic uvp_trip_capable(input logic [1:0] mode,
			input logic stage2);
		return (mode == MODE_ON) || (mode == MODE_A1_T2 && stage2);
	endfunction : uvp_trip_capable
endpackage : uvp_pkg

`timescale 1ns/1ns
`default_nettype none

module uvp_stage #(
	parameter int NCH = 3,
	parameter int TW = uvp_pkg::TW
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NCH-1:0] below_pick,
	input wire logic [NCH-1:0] above_drop,
	input wire logic [NCH-1:0] qualify,
	input wire logic [NCH-1:0] blk_ch,
	input wire logic blk_all,
	input wire logic tick,
	input wire logic [TW-1:0] delay,
	output logic [NCH-1:0] pickup,
	output logic general,
	output logic expired
);
	import uvp_pkg::*;

	typedef struct packed {
		logic [NCH-1:0] pick;
		logic general;
		logic [TW-1:0] cnt;
		logic expired;
	} uvp_stage_t;

	uvp_stage_t r_ff;
	uvp_stage_t nxt_r;

	// latch per channel, shared timer, expiry
	always_comb begin
		nxt_r = r_ff;
		for (int i = 0; i < NCH; i++) begin
			if (blk_all || blk_ch[i]) begin
				nxt_r.pick[i] = 1'b0;
			end else if (r_ff.pick[i]) begin
				nxt_r.pick[i] = !above_drop[i] && qualify[i];
			end else begin
				nxt_r.pick[i] = below_pick[i] && qualify[i];
			end
		end
		nxt_r.general = |nxt_r.pick;
		if (!nxt_r.general) begin
			nxt_r.cnt = '0;
		end else if (tick && r_ff.cnt != '1) begin
			nxt_r.cnt = r_ff.cnt + 1'b1;
		end
		nxt_r.expired = nxt_r.general && (nxt_r.cnt >= delay);
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign pickup = r_ff.pick;
	assign general = r_ff.general;
	assign expired = r_ff.expired;

	property p_block_clears;
		@(posedge clk) disable iff (!rst_n)
		blk_all |=> !general && !expired && r_ff.cnt == '0;
	endproperty
	a_block_clears: assert property (p_block_clears)
		else $error("blocked stage still picked or timing");

	property p_general_any;
		@(posedge clk) disable iff (!rst_n)
		general == (|pickup);
	endproperty
	a_general_any: assert property (p_general_any)
		else $error("general pickup differs from channel pickups");

	property p_expire_needs_pick;
		@(posedge clk) disable iff (!rst_n)
		expired |-> general && r_ff.cnt >= $past(delay, 1);
	endproperty
	a_expire_needs_pick: assert property (p_expire_needs_pick)
		else $error("expiry without pickup or before delay");

	property p_timer_restart;
		@(posedge clk) disable iff (!rst_n)
		($rose(general) && delay > 2) |-> !expired ##1 !expired;
	endproperty
	a_timer_restart: assert property (p_timer_restart)
		else $error("timer expired at pickup");

	property p_pick_cause;
		@(posedge clk) disable iff (!rst_n)
		$rose(pickup[0]) |-> $past(below_pick[0] && qualify[0]);
	endproperty
	a_pick_cause: assert property (p_pick_cause)
		else $error("pickup without undershoot and current");
endmodule : uvp_stage

`default_nettype wire

/* File: uvp_top.sv */
// Purpose: undervoltage decision logic for phase-earth, phase-phase and
//   positive sequence families, two stages each, with blocking.
// Assumes: magnitudes, phasors, current flags, pole state and fuse
//   failure come from same-clock logic; block inputs are raw pins.
// Notes: dropout ratio is unsigned with RATIO_FRAC fraction bits.
`timescale 1ns/1ns
`default_nettype none

module uvp_top #(
	parameter int unsigned TICK_CYCLES = uvp_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0][uvp_pkg::VW-1:0] pe_voltage,
	input wire logic [2:0][uvp_pkg::VW-1:0] pp_voltage,
	input wire logic [2:0][uvp_pkg::VW-1:0] phasor_re,
	input wire logic [2:0][uvp_pkg::VW-1:0] phasor_im,
	input wire logic [1:0][uvp_pkg::VW-1:0] pe_threshold,
	input wire logic [1:0][uvp_pkg::VW-1:0] pp_threshold,
	input wire logic [1:0][uvp_pkg::VW-1:0] ps_threshold,
	input wire logic [1:0][uvp_pkg::TW-1:0] pe_delay,
	input wire logic [1:0][uvp_pkg::TW-1:0] pp_delay,
	input wire logic [uvp_pkg::TW-1:0] pos_seq_low_delay1,
	input wire logic [uvp_pkg::TW-1:0] pos_seq_low_delay2,
	input wire logic [15:0] pe_dropout_ratio,
	input wire logic [15:0] pp_dropout_ratio,
	input wire logic [15:0] ps_dropout_ratio,
	input wire logic [1:0] pe_mode,
	input wire logic [1:0] pp_mode,
	input wire logic [1:0] ps_mode,
	input wire logic phase_earth_current_supervision,
	input wire logic phase_phase_current_supervision,
	input wire logic pos_seq_current_supervision,
	input wire logic current_inputs_present,
	input wire logic all_cts_connected,
	input wire logic all_vts_connected,
	input wire logic vt_outgoing_side,
	input wire logic [2:0] current_flow,
	input wire logic [2:0] pole_open,
	input wire logic single_pole_dead_time,
	input wire logic [2:0] fuse_fail_phase,
	input wire logic phase_earth_low_block_in,
	input wire logic phase_phase_low_block_in,
	input wire logic pos_seq_low_block_in,
	input wire logic vt_breaker_trip_in,
	output logic [1:0][2:0] pe_stage_pickup,
	output logic [1:0] pe_general_pickup,
	output logic [1:0] pe_expired,
	output logic pe_trip,
	output logic [1:0][2:0] pp_pair_pickup,
	output logic [1:0][2:0] pp_phase_pickup,
	output logic [1:0] pp_general_pickup,
	output logic [1:0] pp_expired,
	output logic pp_trip,
	output logic [1:0] ps_general_pickup,
	output logic [1:0] ps_expired,
	output logic ps_trip
);
	import uvp_pkg::*;

	typedef struct packed {
		logic [3:0] bin_s1;
		logic [3:0] bin_s2;
		logic [31:0] tick_cnt;
		logic tick;
		logic signed [18:0] s_re;
		logic signed [18:0] s_im;
		logic pe_trip;
		logic pp_trip;
		logic ps_trip;
		logic [1:0][2:0] pp_phase;
	} uvp_top_t;

	uvp_top_t r_ff;
	uvp_top_t nxt_r;

	// dropout level = threshold times ratio
	function automatic logic [23:0] uvp_drop(input logic [15:0] thr,
			input logic [15:0] ratio);
		logic [31:0] p;
		p = thr * ratio;
		return p[23+RATIO_FRAC:RATIO_FRAC];
	endfunction : uvp_drop

	// product with sqrt(3)/2, kept 17 bits signed
	function automatic logic signed [18:0] uvp_mul_k(input logic [15:0] x);
		logic signed [32:0] p;
		p = $signed(x) * $signed(SQRT3_HALF);
		return 19'($signed(p[32:16])); // keep the sign of the product
	endfunction : uvp_mul_k

	// half of a signed component
	function automatic logic signed [18:0] uvp_half(input logic [15:0] x);
		logic signed [15:0] h;
		h = $signed(x) >>> 1;
		return 19'(h);
	endfunction : uvp_half

	logic fuse_any;
	logic vt_blk;
	logic auto_ok;
	logic sup_pe;
	logic sup_pp;
	logic sup_ps;
	logic [2:0] q_pe;
	logic [2:0] q_pp;
	logic q_ps;
	logic [1:0][2:0] pe_below;
	logic [1:0][2:0] pe_above;
	logic [1:0][2:0] pp_below;
	logic [1:0][2:0] pp_above;
	logic [1:0] ps_below;
	logic [1:0] ps_above;
	logic [1:0][2:0] pe_blk_ch;
	logic [1:0][2:0] pp_blk_ch;
	logic [1:0] pe_blk;
	logic [1:0] pp_blk;
	logic [1:0] ps_blk;
	logic [1:0] pe_cap;
	logic [1:0] pp_cap;
	logic [1:0] ps_cap;
	logic [39:0] ps_mag2;
	logic [1:0][TW-1:0] ps_delay;
	logic [1:0][2:0] pp_pick_w;
	logic [1:0] pe_exp_w;
	logic [1:0] pp_exp_w;
	logic [1:0] ps_exp_w;

	// shared blocking and supervision terms
	always_comb begin
		fuse_any = |fuse_fail_phase;
		vt_blk = r_ff.bin_s2[BIN_VT];
		auto_ok = all_cts_connected && all_vts_connected &&
			single_pole_dead_time;
		sup_pe = phase_earth_current_supervision && current_inputs_present;
		sup_pp = phase_phase_current_supervision && current_inputs_present;
		sup_ps = pos_seq_current_supervision && current_inputs_present;
		q_ps = !sup_ps || (|current_flow);
		ps_mag2 = 40'(r_ff.s_re) * 40'(r_ff.s_re) +
			40'(r_ff.s_im) * 40'(r_ff.s_im);
		ps_delay[0] = pos_seq_low_delay1;
		ps_delay[1] = pos_seq_low_delay2;
	end

	// per stage and per phase compare and block
	for (genvar s = 0; s < 2; s++) begin : g_stage
		assign pe_cap[s] = uvp_trip_capable(pe_mode, s == 1);
		assign pp_cap[s] = uvp_trip_capable(pp_mode, s == 1);
		assign ps_cap[s] = uvp_trip_capable(ps_mode, s == 1);
		assign pe_blk[s] = pe_mode == MODE_OFF || fuse_any || vt_blk ||
			r_ff.bin_s2[BIN_PE];
		assign pp_blk[s] = pp_mode == MODE_OFF || vt_blk ||
			r_ff.bin_s2[BIN_PP];
		assign ps_blk[s] = ps_mode == MODE_OFF || fuse_any || vt_blk ||
			r_ff.bin_s2[BIN_PS] || (auto_ok && (|pole_open));
		assign ps_below[s] = {16'h0, ps_mag2} <
			56'({2'h0, ps_threshold[s]} * 18'h00003) *
			56'({2'h0, ps_threshold[s]} * 18'h00003);
		assign ps_above[s] = {16'h0, ps_mag2} >=
			56'({2'h0, uvp_drop(ps_threshold[s], ps_dropout_ratio)} *
			26'h0000003) * 56'({2'h0, uvp_drop(ps_threshold[s],
			ps_dropout_ratio)} * 26'h0000003);
		for (genvar i = 0; i < 3; i++) begin : g_ph
			localparam int J = (i + 1) % 3;
			assign pe_below[s][i] = pe_voltage[i] < pe_threshold[s];
			assign pe_above[s][i] = {8'h0, pe_voltage[i]} >=
				uvp_drop(pe_threshold[s], pe_dropout_ratio);
			assign pp_below[s][i] = pp_voltage[i] < pp_threshold[s];
			assign pp_above[s][i] = {8'h0, pp_voltage[i]} >=
				uvp_drop(pp_threshold[s], pp_dropout_ratio);
			assign pe_blk_ch[s][i] = auto_ok && pe_cap[s] &&
				pole_open[i];
			assign pp_blk_ch[s][i] = fuse_fail_phase[i] || fuse_fail_phase[J] ||
				(auto_ok && vt_outgoing_side && pp_cap[s] &&
				(pole_open[i] || pole_open[J]));
		end
	end

	// current qualifiers per phase and per pair
	for (genvar i = 0; i < 3; i++) begin : g_qual
		assign q_pe[i] = !sup_pe || current_flow[i];
		assign q_pp[i] = !sup_pp || current_flow[i] ||
			current_flow[(i + 1) % 3];
	end

	// two stages of each family
	for (genvar s = 0; s < 2; s++) begin : g_fam
		uvp_stage #(.NCH(3), .TW(TW)) u_pe (
			.clk(clk),
			.rst_n(rst_n),
			.below_pick(pe_below[s]),
			.above_drop(pe_above[s]),
			.qualify(q_pe),
			.blk_ch(pe_blk_ch[s]),
			.blk_all(pe_blk[s]),
			.tick(r_ff.tick),
			.delay(pe_delay[s]),
			.pickup(pe_stage_pickup[s]),
			.general(pe_general_pickup[s]),
			.expired(pe_exp_w[s])
		);
		uvp_stage #(.NCH(3), .TW(TW)) u_pp (
			.clk(clk),
			.rst_n(rst_n),
			.below_pick(pp_below[s]),
			.above_drop(pp_above[s]),
			.qualify(q_pp),
			.blk_ch(pp_blk_ch[s]),
			.blk_all(pp_blk[s]),
			.tick(r_ff.tick),
			.delay(pp_delay[s]),
			.pickup(pp_pick_w[s]),
			.general(pp_general_pickup[s]),
			.expired(pp_exp_w[s])
		);
		uvp_stage #(.NCH(1), .TW(TW)) u_ps (
			.clk(clk),
			.rst_n(rst_n),
			.below_pick(ps_below[s]),
			.above_drop(ps_above[s]),
			.qualify(q_ps),
			.blk_ch(1'b0),
			.blk_all(ps_blk[s]),
			.tick(r_ff.tick),
			.delay(ps_delay[s]),
			.pickup(),
			.general(ps_general_pickup[s]),
			.expired(ps_exp_w[s])
		);
	end

	assign pe_expired = pe_exp_w;
	assign pp_expired = pp_exp_w;
	assign ps_expired = ps_exp_w;
	assign pp_pair_pickup = pp_pick_w;

	// synchronisers, tick, positive sequence sum, trips, phase indication
	always_comb begin
		nxt_r = r_ff;
		nxt_r.bin_s1 = {vt_breaker_trip_in, pos_seq_low_block_in,
			phase_phase_low_block_in, phase_earth_low_block_in};
		nxt_r.bin_s2 = r_ff.bin_s1;
		nxt_r.tick = r_ff.tick_cnt == 32'(TICK_CYCLES - 1);
		nxt_r.tick_cnt = nxt_r.tick ? 32'h00000000 : r_ff.tick_cnt + 1'b1;
		nxt_r.s_re = 19'($signed(phasor_re[0])) - uvp_half(phasor_re[1]) -
			uvp_mul_k(phasor_im[1]) - uvp_half(phasor_re[2]) +
			uvp_mul_k(phasor_im[2]);
		nxt_r.s_im = 19'($signed(phasor_im[0])) + uvp_mul_k(phasor_re[1]) -
			uvp_half(phasor_im[1]) - uvp_mul_k(phasor_re[2]) -
			uvp_half(phasor_im[2]);
		nxt_r.pe_trip = |(pe_exp_w & pe_cap);
		nxt_r.pp_trip = |(pp_exp_w & pp_cap);
		nxt_r.ps_trip = |(ps_exp_w & ps_cap);
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 3; i++) begin
				nxt_r.pp_phase[s][i] = pp_pick_w[s][i] ||
					pp_pick_w[s][(i + 2) % 3];
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign pe_trip = r_ff.pe_trip;
	assign pp_trip = r_ff.pp_trip;
	assign ps_trip = r_ff.ps_trip;
	assign pp_phase_pickup = r_ff.pp_phase;

	property p_pe_trip_mode;
		@(posedge clk) disable iff (!rst_n)
		pe_trip |-> $past(|(pe_exp_w & pe_cap));
	endproperty
	a_pe_trip_mode: assert property (p_pe_trip_mode)
		else $error("phase-earth trip without trip-capable expiry");

	property p_vt_block;
		@(posedge clk) disable iff (!rst_n)
		(r_ff.bin_s2[BIN_VT] && pe_mode != MODE_OFF) |=>
			pe_general_pickup == 2'b00 && ps_general_pickup == 2'b00;
	endproperty
	a_vt_block: assert property (p_vt_block)
		else $error("stage picked during breaker trip block");

	property p_pp_pair;
		@(posedge clk) disable iff (!rst_n)
		pp_pair_pickup[0][0] |=> pp_phase_pickup[0][0] &&
			pp_phase_pickup[0][1];
	endproperty
	a_pp_pair: assert property (p_pp_pair)
		else $error("pair pickup did not mark both phases");

	property p_dead_pe;
		@(posedge clk) disable iff (!rst_n)
		(auto_ok && pe_mode == MODE_ON && pole_open[0]) |=>
			!pe_stage_pickup[0][0] && !pe_stage_pickup[1][0];
	endproperty
	a_dead_pe: assert property (p_dead_pe)
		else $error("open pole picked during dead time");

	property p_alarm_active;
		@(posedge clk) disable iff (!rst_n)
		(pe_mode == MODE_ALARM) |-> pe_blk_ch == '0;
	endproperty
	a_alarm_active: assert property (p_alarm_active)
		else $error("alarm-only stage blocked in dead time");

	property p_no_ct;
		@(posedge clk) disable iff (!rst_n)
		!current_inputs_present |-> q_pe == 3'b111 && q_pp == 3'b111 && q_ps;
	endproperty
	a_no_ct: assert property (p_no_ct)
		else $error("current criterion active without current inputs");

	property p_pin_sync;
		@(posedge clk) disable iff (!rst_n)
		$rose(phase_earth_low_block_in) ##1 phase_earth_low_block_in
			|=> r_ff.bin_s2[BIN_PE];
	endproperty
	a_pin_sync: assert property (p_pin_sync)
		else $error("block input not seen after two flops");
endmodule : uvp_top

`default_nettype wire

/* File: uvp_front_model.sv */
// Purpose: model of the measurement front end and function control
// Assumes: one clock shared with the decision logic
// Notes: open_idx 3 means all poles closed; open poles carry no current
`timescale 1ns/1ns
`default_nettype none

module uvp_front_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] flow_mask,
	input wire logic [1:0] open_idx,
	input wire logic [2:0] fuse_req,
	output logic [2:0] current_flow,
	output logic [2:0] pole_open,
	output logic single_pole_dead_time,
	output logic [2:0] fuse_fail_phase
);
	logic [2:0] open_dec;

	// decode the one open pole
	always_comb begin
		open_dec = 3'h0;
		if (open_idx != 2'h3) begin
			open_dec[open_idx] = 1'b1;
		end
	end

	// status registered as the control function reports it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			current_flow <= 3'h0;
			pole_open <= 3'h0;
			single_pole_dead_time <= 1'b0;
			fuse_fail_phase <= 3'h0;
		end else begin
			current_flow <= flow_mask & ~open_dec; // no flow in open pole
			pole_open <= open_dec;
			single_pole_dead_time <= |open_dec;
			fuse_fail_phase <= fuse_req;
		end
	end
endmodule : uvp_front_model

`default_nettype wire

/* File: uvp_top_bench.sv */
// Purpose: self-checking bench for the undervoltage decision logic
// Assumes: tick shortened to 4 clocks, delays of a few ticks
// Notes: inputs change at the rising edge, checks at the falling edge
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin \
	miscompares++; $display("CHECK FAILED at %0t: %s", $time, m); end end

module uvp_top_bench;
	import uvp_pkg::*;
	localparam int unsigned TK = 4;
	localparam int LIMIT = 5000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	int cmp_count = 0;
	int miscompares = 0;
	int cyc = 0;
	logic [2:0][VW-1:0] pe_voltage, pp_voltage, phasor_re, phasor_im;
	logic [1:0][VW-1:0] pe_threshold, pp_threshold, ps_threshold;
	logic [1:0][TW-1:0] pe_delay, pp_delay;
	logic [TW-1:0] pos_seq_low_delay1, pos_seq_low_delay2;
	logic [15:0] pe_dropout_ratio, pp_dropout_ratio, ps_dropout_ratio;
	logic [1:0] pe_mode, pp_mode, ps_mode, open_idx;
	logic phase_earth_current_supervision, phase_phase_current_supervision;
	logic pos_seq_current_supervision, current_inputs_present;
	logic all_cts_connected, all_vts_connected, vt_outgoing_side;
	logic single_pole_dead_time, pe_trip, pp_trip, ps_trip;
	logic [2:0] current_flow, pole_open, fuse_fail_phase, flow_mask, fuse_req;
	logic phase_earth_low_block_in, phase_phase_low_block_in;
	logic pos_seq_low_block_in, vt_breaker_trip_in;
	logic [1:0][2:0] pe_stage_pickup, pp_pair_pickup, pp_phase_pickup;
	logic [1:0] pe_general_pickup, pe_expired, pp_general_pickup, pp_expired;
	logic [1:0] ps_general_pickup, ps_expired;
	logic [2:0] gen;
	int fl[4] = '{0, 2, 4, 4};
	int ex[5];

	uvp_top #(.TICK_CYCLES(TK)) dut_u (.clk, .rst_n, .pe_voltage, .pp_voltage,
		.phasor_re, .phasor_im, .pe_threshold, .pp_threshold, .ps_threshold,
		.pe_delay, .pp_delay, .pos_seq_low_delay1, .pos_seq_low_delay2,
		.pe_dropout_ratio, .pp_dropout_ratio, .ps_dropout_ratio, .pe_mode,
		.pp_mode, .ps_mode, .phase_earth_current_supervision,
		.phase_phase_current_supervision, .pos_seq_current_supervision,
		.current_inputs_present, .all_cts_connected, .all_vts_connected,
		.vt_outgoing_side, .current_flow, .pole_open, .single_pole_dead_time,
		.fuse_fail_phase, .phase_earth_low_block_in, .phase_phase_low_block_in,
		.pos_seq_low_block_in, .vt_breaker_trip_in, .pe_stage_pickup,
		.pe_general_pickup, .pe_expired, .pe_trip, .pp_pair_pickup,
		.pp_phase_pickup, .pp_general_pickup, .pp_expired, .pp_trip,
		.ps_general_pickup, .ps_expired, .ps_trip);

	uvp_front_model model_u (.clk, .rst_n, .flow_mask, .open_idx, .fuse_req,
		.current_flow, .pole_open, .single_pole_dead_time, .fuse_fail_phase);

	// free clock and cycle ceiling
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			miscompares++;
			report_and_stop();
		end
	end

	assign gen = {pe_general_pickup[0], pp_general_pickup[0],
		ps_general_pickup[0]};

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic at();
		@(posedge clk);
	endtask : at

	task automatic go(input int n);
		repeat (n) @(negedge clk);
	endtask : go

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	// balanced phasors of magnitude m, L2 lagging and L3 leading
	task automatic ps_set(input int m);
		int h;
		h = m * 866 / 1000;
		phasor_re <= {VW'(-m / 2), VW'(-m / 2), VW'(m)};
		phasor_im <= {VW'(h), VW'(-h), VW'(0)};
	endtask : ps_set

	// healthy system, all stages on, no supervision
	task automatic base();
		pe_voltage <= {3{16'h0FA0}};
		pp_voltage <= {3{16'h1B10}};
		ps_set(4000);
		pe_threshold <= {16'h01F4, 16'h03E8};
		pp_threshold <= {16'h01F4, 16'h03E8};
		ps_threshold <= {16'h01F4, 16'h03E8};
		pe_delay <= {2{16'h0003}};
		pp_delay <= {2{16'h0003}};
		pos_seq_low_delay1 <= 16'h0002;
		pos_seq_low_delay2 <= 16'h0005;
		{pe_dropout_ratio, pp_dropout_ratio, ps_dropout_ratio} <= {3{16'h0100}};
		{pe_mode, pp_mode, ps_mode} <= {3{2'h1}};
		{phase_earth_current_supervision, phase_phase_current_supervision,
			pos_seq_current_supervision} <= 3'h0;
		{current_inputs_present, all_cts_connected, all_vts_connected} <= 3'h7;
		vt_outgoing_side <= 1'b0;
		flow_mask <= 3'h7;
		open_idx <= 2'h3;
		fuse_req <= 3'h0;
		{phase_earth_low_block_in, phase_phase_low_block_in,
			pos_seq_low_block_in, vt_breaker_trip_in} <= 4'h0;
	endtask : base

	task automatic fresh();
		at();
		base();
		at();
	endtask : fresh

	function automatic logic sel(input int w);
		case (w)
			0: return pe_expired[0];
			1: return ps_expired[0];
			default: return ps_expired[1];
		endcase
	endfunction : sel

	// negedges until the chosen expiry rises, bounded
	task automatic wait_for(input int w, input int lo, input int hi);
		int n;
		n = 0;
		while (sel(w) !== 1'b1 && n <= hi) begin
			go(1);
			n++;
		end
		`CHK(n >= lo && n <= hi, 1'b1, "expiry time off")
	endtask : wait_for

	// main sequence
	initial begin
		base();
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		go(1);
		`CHK({gen, pe_trip, pp_trip, ps_trip}, 6'h00, "reset")
		done("reset");
		at();
		pe_voltage[0] <= 16'h0300;
		wait_for(0, 8, 19);
		`CHK({pe_stage_pickup, pe_general_pickup}, 8'h05, "pe pickup")
		go(1);
		`CHK({pe_trip, pe_expired}, 3'h5, "pe trip")
		fresh();
		ps_set(400);
		wait_for(1, 4, 16);
		`CHK(ps_expired, 2'h1, "ps stages")
		wait_for(2, 8, 16);
		go(1);
		`CHK(ps_trip, 1'b1, "ps trip")
		done("timers");
		fresh();
		pe_dropout_ratio <= 16'h0140;
		pe_voltage[0] <= 16'h0300;
		go(5);
		at();
		pe_voltage[0] <= 16'h04B0;
		go(5);
		`CHK(pe_general_pickup[0], 1'b1, "held in band")
		at();
		pe_voltage[0] <= 16'h0514;
		go(5);
		`CHK(pe_general_pickup[0], 1'b0, "released")
		done("dropout");
		fresh();
		{phase_earth_current_supervision, phase_phase_current_supervision,
			pos_seq_current_supervision} <= 3'h7;
		pe_voltage[1] <= 16'h0300;
		pp_voltage[0] <= 16'h0300;
		ps_set(600);
		ex = '{0, 7, 1, 7, 0};
		for (int i = 0; i < 4; i++) begin
			at();
			flow_mask <= 3'(fl[i]);
			current_inputs_present <= (i != 3);
			go(5);
			`CHK(gen, 3'(ex[i]), "supervision")
		end
		done("supervision");
		fresh();
		pe_voltage[1] <= 16'h0300;
		pp_voltage[0] <= 16'h0300;
		ps_set(600);
		ex = '{3, 5, 6, 0, 0};
		for (int s = 0; s < 5; s++) begin
			at();
			case (s)
				0: phase_earth_low_block_in <= 1'b1;
				1: phase_phase_low_block_in <= 1'b1;
				2: pos_seq_low_block_in <= 1'b1;
				3: vt_breaker_trip_in <= 1'b1;
				default: fuse_req <= 3'h7;
			endcase
			go(5);
			`CHK(gen, 3'(ex[s]), "blocked")
			`CHK(pe_expired[0], 1'(ex[s] >> 2), "pe timer")
			at();
			{phase_earth_low_block_in, phase_phase_low_block_in,
				pos_seq_low_block_in, vt_breaker_trip_in} <= 4'h0;
			fuse_req <= 3'h0;
			go(16);
			`CHK(gen, 3'h7, "unblocked")
		end
		done("blocking");
		fresh();
		pe_voltage[0] <= 16'h0000;
		open_idx <= 2'h0;
		ex = '{3, 0, 1, 3, 0};
		for (int i = 0; i < 5; i++) begin
			at();
			pe_mode <= (i == 0) ? 2'h2 : (i == 2) ? 2'h3 :
				(i == 4) ? 2'h0 : 2'h1;
			all_cts_connected <= (i != 3);
			go(6);
			`CHK({pe_stage_pickup[1][0], pe_stage_pickup[0][0]}, 2'(ex[i]), "dead")
		end
		done("dead time pe");
		fresh();
		pp_voltage[0] <= 16'h0300;
		go(5);
		`CHK({pp_pair_pickup[0], pp_phase_pickup[0]}, 6'h0B, "pp pair")
		at();
		fuse_req <= 3'h4;
		go(14);
		`CHK(pp_pair_pickup[0][0], 1'b1, "other pair fuse")
		`CHK({pp_expired[0], pp_trip}, 2'h3, "pp trip")
		at();
		fuse_req <= 3'h1;
		go(5);
		`CHK(pp_pair_pickup[0][0], 1'b0, "own pair fuse")
		`CHK({pp_expired[0], pp_trip}, 2'h0, "pp cleared")
		fresh();
		ps_set(600);
		pp_voltage[2] <= 16'h0000;
		vt_outgoing_side <= 1'b1;
		open_idx <= 2'h2;
		go(6);
		`CHK({pp_pair_pickup[0][2], ps_general_pickup[0]}, 2'h0, "dead pp ps")
		at();
		vt_outgoing_side <= 1'b0;
		go(6);
		`CHK({pp_pair_pickup[0][2], ps_general_pickup[0]}, 2'h2, "bus side")
		done("phase pairs");
		report_and_stop();
	end
endmodule : uvp_top_bench

`default_nettype wire
